// ---- hw/tlic_pkg.sv ----
package tlic_pkg;

   localparam int NUM_SRC = 15;
   localparam int APB_ADDR_W = 8;

   // register byte offsets
   localparam logic [7:0] OFF_ENABLE_PRIMARY = 8'hA8;
   localparam logic [7:0] OFF_PRIORITY_PRIMARY = 8'hB8;
   localparam logic [7:0] OFF_ENABLE_TIMER2 = 8'hE8;
   localparam logic [7:0] OFF_PRIORITY_TIMER2 = 8'hF8;
   localparam logic [7:0] OFF_TRIGGER_MODE = 8'hC0;
   localparam logic [7:0] OFF_CAPTURE_EDGE = 8'hC4;
   localparam logic [7:0] OFF_STATUS = 8'hC8;

   // reset values
   localparam logic [7:0] RST_ENABLE_PRIMARY = 8'h00;
   localparam logic [7:0] RST_PRIORITY_PRIMARY = 8'h00;
   localparam logic [7:0] RST_ENABLE_TIMER2 = 8'h00;
   localparam logic [7:0] RST_PRIORITY_TIMER2 = 8'h00;
   localparam logic [7:0] RST_TRIGGER_MODE = 8'h00;
   localparam logic [7:0] RST_CAPTURE_EDGE = 8'h00;

   // field positions
   localparam int GLOBAL_GATE_BIT = 7;
   localparam int MODE_EXT0_EDGE_BIT = 0;
   localparam int MODE_EXT1_EDGE_BIT = 1;
   localparam int MODE_CAP_PIN_LSB = 2;
   localparam int CAPEDGE_RISE_LSB = 0;
   localparam int CAPEDGE_FALL_LSB = 4;
   localparam int STAT_SVC_LOW_BIT = 16;
   localparam int STAT_SVC_HIGH_BIT = 17;
   localparam int STAT_REQ_BIT = 18;

   // source indices in vector order
   localparam logic [3:0] SRC_EXT0 = 4'h0;
   localparam logic [3:0] SRC_EXT1 = 4'h2;
   localparam logic [3:0] SRC_CAP0 = 4'h6;
   localparam logic [14:0] CAPTURE_SRC_MASK = 15'h03C0;

   // equal-level service order, entry 0 (the last listed) wins
   localparam logic [14:0][3:0] SERVICE_ORDER = {
      4'hE, 4'h9, 4'h4, 4'hD, 4'h8, 4'h3, 4'hC, 4'h7,
      4'h2, 4'hB, 4'h6, 4'h1, 4'hA, 4'h5, 4'h0};

   localparam logic [15:0] VECTOR_BASE = 16'h0003;
   localparam int VECTOR_STEP_SHIFT = 3;

   // response timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int RESP_MIN_NS = 2250;
   localparam int RESP_MAX_NS = 7500;
   localparam int RESP_MIN_CYC = (RESP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESP_MAX_CYC = RESP_MAX_NS / CLK_PERIOD_NS;
   localparam logic [7:0] RESP_MIN_LAST = 8'(RESP_MIN_CYC - 1);

   typedef enum logic [1:0] {
      TLIC_ST_IDLE = 2'b00,
      TLIC_ST_WAIT = 2'b01,
      TLIC_ST_OFFER = 2'b11
   } tlic_state_t;

endpackage : tlic_pkg

// ---- hw/tlic_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module tlic_pin_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // asynchronous pins
   input wire logic [W-1:0] i_pin,
   // synchronised level and edge pulses
   output logic [W-1:0] o_level,
   output logic [W-1:0] o_rise,
   output logic [W-1:0] o_fall
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
      logic [W-1:0] prev;
   } tlic_sync_state_t;

   tlic_sync_state_t s_q;
   tlic_sync_state_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.meta = i_pin;
      s_d.stable = s_q.meta;
      s_d.prev = s_q.stable;
   end

   // resets to zero; callers needing idle-high pins see one false edge at most after reset
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_level = s_q.stable;
   assign o_rise = s_q.stable & ~s_q.prev;
   assign o_fall = ~s_q.stable & s_q.prev;

endmodule : tlic_pin_sync

`default_nettype wire

// ---- hw/tlic_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none

// How it works
// - fifteen sources: pins, timers, capture, ADC, CAN, UART
// - two levels, nested service in-service tracking
// - CAN DMA transfer blocks all acceptance
// - capture pins usable as edge external requests
// - capture requests never end idle mode
// - second timer gives eight separate requests
// - each source has its own vector
// - primary enable bit 7 gates everything
// - external inputs level or transition triggered
// - external inputs active low, wired-OR capable
// - primary enable bits 6..0 per source
// - timer2 enable register bit layout
// - primary priority bits 6..0, bit 7 unused
// - one priority bit per source
// - request offered after minimum response latency
// - timer2 priority register bit layout
// - fixed order among equal-level requests
// - low preempted by high only; high never
// - vectors from 0003H stepping eight bytes
module tlic_ctrl (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [tlic_pkg::APB_ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   // external pins, asynchronous
   input wire logic [1:0] i_external_request_n,
   input wire logic [3:0] i_capture_pin,
   // on-chip peripheral requests, active high levels
   input wire logic i_timer0_irq,
   input wire logic i_timer1_irq,
   input wire logic i_uart_irq,
   input wire logic i_can_irq,
   input wire logic i_adc_irq,
   input wire logic [3:0] i_t2_capture_irq,
   input wire logic [2:0] i_t2_compare_irq,
   input wire logic i_t2_overflow_irq,
   // system state
   input wire logic i_can_dma_busy,
   input wire logic i_idle_mode,
   // cpu core
   input wire logic i_cpu_ack,
   input wire logic i_cpu_reti,
   output logic o_irq_req,
   output logic [15:0] o_irq_vector,
   output logic o_irq_high,
   output logic o_idle_wake
);
   import tlic_pkg::*;

   typedef struct packed {
      logic [7:0] en_pri;
      logic [6:0] pri_pri;
      logic [7:0] en_t2;
      logic [7:0] pri_t2;
      logic [7:0] mode;
      logic [7:0] capedge;
      logic [14:0] edge_flag;
      tlic_state_t fsm;
      logic [7:0] cnt;
      logic [3:0] sel;
      logic sel_high;
      logic svc_high;
      logic svc_low;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic irq_req;
      logic [15:0] vector;
      logic wake;
   } tlic_ctrl_state_t;

   tlic_ctrl_state_t s_q;
   tlic_ctrl_state_t s_d;

   logic rst_sync_n;
   logic [5:0] pin_level;
   logic [5:0] pin_rise;
   logic [5:0] pin_fall;

   // reset release through two flops
   tlic_pin_sync #(.W(1)) u_rst_sync (
      .i_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_pin(1'b1),
      .o_level(rst_sync_n),
      .o_rise(),
      .o_fall()
   );

   // bits 1:0 external request pins, 5:2 capture pins
   tlic_pin_sync #(.W(6)) u_pin_sync (
      .i_clk(i_sys_clk),
      .i_rst_n(rst_sync_n),
      .i_pin({i_capture_pin, i_external_request_n}),
      .o_level(pin_level),
      .o_rise(pin_rise),
      .o_fall(pin_fall)
   );

   // spread the two 8-bit registers onto vector order
   function automatic logic [14:0] map_bits(input logic [6:0] prim, input logic [7:0] t2);
      map_bits = {t2[7], t2[6:4], prim[6], t2[3:0], prim[5:0]};
   endfunction : map_bits

   // first requesting source in service order
   function automatic logic [4:0] pick(input logic [14:0] req);
      logic [4:0] res;
      res = 5'h00;
      for (int k = NUM_SRC - 1; k >= 0; k--) begin
         if (req[SERVICE_ORDER[k]]) begin
            res = {1'b1, SERVICE_ORDER[k]};
         end
      end
      pick = res;
   endfunction : pick

   function automatic logic [15:0] vector_of(input logic [3:0] idx);
      vector_of = VECTOR_BASE + ({12'h000, idx} << VECTOR_STEP_SHIFT);
   endfunction : vector_of

   function automatic logic [31:0] zext8(input logic [7:0] v);
      zext8 = {24'h000000, v};
   endfunction : zext8

   logic [14:0] req;
   logic [14:0] en_vec;
   logic [14:0] hi_vec;
   logic [14:0] cand;
   logic [4:0] win_hi;
   logic [4:0] win_lo;
   logic [4:0] win;
   logic gate;
   logic apb_access;
   logic apb_commit;
   logic [3:0] cap_edge_hit;
   logic [14:0] edge_set;

   always_comb begin
      s_d = s_q;

      // capture pin edges selected per pin and direction
      cap_edge_hit = (pin_rise[5:2] & s_q.capedge[CAPEDGE_RISE_LSB +: 4])
                   | (pin_fall[5:2] & s_q.capedge[CAPEDGE_FALL_LSB +: 4]);

      // latched edge events; timer2 is stopped during idle so capture pin edges are not seen, external pin edges still are
      edge_set = '0;
      for (int n = 0; n < 2; n++) begin
         if (s_q.mode[MODE_EXT0_EDGE_BIT + n] && pin_fall[n]) begin
            edge_set[2 * n] = 1'b1;
         end
      end
      for (int n = 0; n < 4; n++) begin
         if (s_q.mode[MODE_CAP_PIN_LSB + n] && cap_edge_hit[n] && !i_idle_mode) begin
            edge_set[int'(SRC_CAP0) + n] = 1'b1;
         end
      end
      // a fresh edge beats the ack clear below, so no request is lost
      s_d.edge_flag = s_q.edge_flag | edge_set;

      // request vector in vector order
      req[0] = s_q.mode[MODE_EXT0_EDGE_BIT] ? s_q.edge_flag[0] : ~pin_level[0];
      req[1] = i_timer0_irq;
      req[2] = s_q.mode[MODE_EXT1_EDGE_BIT] ? s_q.edge_flag[2] : ~pin_level[1];
      req[3] = i_timer1_irq;
      req[4] = i_uart_irq;
      req[5] = i_can_irq;
      for (int n = 0; n < 4; n++) begin
         req[6 + n] = s_q.mode[MODE_CAP_PIN_LSB + n] ? s_q.edge_flag[6 + n]
                                                     : i_t2_capture_irq[n];
      end
      req[10] = i_adc_irq;
      req[13:11] = i_t2_compare_irq;
      req[14] = i_t2_overflow_irq;

      en_vec = map_bits(s_q.en_pri[6:0], s_q.en_t2);
      hi_vec = map_bits(s_q.pri_pri, s_q.pri_t2);
      gate = s_q.en_pri[GLOBAL_GATE_BIT] && !i_can_dma_busy;

      // nesting: nothing beats a high routine, only high beats a low one
      cand = '0;
      if (gate && !s_q.svc_high) begin
         cand = req & en_vec & (s_q.svc_low ? hi_vec : 15'h7FFF);
      end
      win_hi = pick(cand & hi_vec);
      win_lo = pick(cand & ~hi_vec);
      win = win_hi[4] ? win_hi : win_lo;

      // capture-derived requests cannot end idle mode
      s_d.wake = i_idle_mode && gate && |(req & en_vec & ~CAPTURE_SRC_MASK);

      // return from a routine pops the innermost level
      if (i_cpu_reti) begin
         if (s_q.svc_high) begin
            s_d.svc_high = 1'b0;
         end else begin
            s_d.svc_low = 1'b0;
         end
      end

      case (s_q.fsm)
         TLIC_ST_IDLE: begin
            s_d.cnt = 8'h00;
            if (win[4]) begin
               s_d.fsm = TLIC_ST_WAIT;
            end
         end
         TLIC_ST_WAIT: begin
            // the winner is re-evaluated each cycle until it is offered
            if (!win[4]) begin
               s_d.fsm = TLIC_ST_IDLE;
            end else if (s_q.cnt == RESP_MIN_LAST) begin
               s_d.fsm = TLIC_ST_OFFER;
               s_d.irq_req = 1'b1;
               s_d.sel = win[3:0];
               s_d.sel_high = win_hi[4];
               s_d.vector = vector_of(win[3:0]);
            end else begin
               s_d.cnt = s_q.cnt + 8'h01;
            end
         end
         TLIC_ST_OFFER: begin
            if (i_cpu_ack) begin
               s_d.irq_req = 1'b0;
               s_d.fsm = TLIC_ST_IDLE;
               if (s_q.sel_high) begin
                  s_d.svc_high = 1'b1;
               end else begin
                  s_d.svc_low = 1'b1;
               end
               // an edge arriving in the same cycle as the ack keeps its flag
               for (int n = 0; n < NUM_SRC; n++) begin
                  if (4'(n) == s_q.sel && !edge_set[n]) begin
                     s_d.edge_flag[n] = 1'b0;
                  end
               end
            end else if (!cand[s_q.sel]) begin
               // withdrawn: gate dropped, DMA started or source disabled
               s_d.irq_req = 1'b0;
               s_d.fsm = TLIC_ST_IDLE;
            end
         end
         default: begin
            s_d.fsm = TLIC_ST_IDLE;
            s_d.irq_req = 1'b0;
         end
      endcase

      // apb: one wait state, answer registered so all outputs come from flops
      apb_access = i_psel && i_penable;
      apb_commit = apb_access && s_q.pready;
      s_d.pready = apb_access && !s_q.pready;
      if (apb_access && !s_q.pready) begin
         s_d.pslverr = 1'b0;
         s_d.prdata = 32'h00000000;
         case (i_paddr)
            OFF_ENABLE_PRIMARY: s_d.prdata = zext8(s_q.en_pri);
            OFF_PRIORITY_PRIMARY: s_d.prdata = zext8({1'b0, s_q.pri_pri});
            OFF_ENABLE_TIMER2: s_d.prdata = zext8(s_q.en_t2);
            OFF_PRIORITY_TIMER2: s_d.prdata = zext8(s_q.pri_t2);
            OFF_TRIGGER_MODE: s_d.prdata = zext8(s_q.mode);
            OFF_CAPTURE_EDGE: s_d.prdata = zext8(s_q.capedge);
            OFF_STATUS: begin
               s_d.prdata[14:0] = req;
               s_d.prdata[STAT_SVC_LOW_BIT] = s_q.svc_low;
               s_d.prdata[STAT_SVC_HIGH_BIT] = s_q.svc_high;
               s_d.prdata[STAT_REQ_BIT] = s_q.irq_req;
            end
            default: s_d.pslverr = 1'b1;
         endcase
         if (!i_pwrite) begin
            s_d.prdata = s_d.pslverr ? 32'h00000000 : s_d.prdata;
         end else begin
            s_d.prdata = 32'h00000000;
         end
      end else begin
         // error stands only beside pready, never into the release cycle
         s_d.pslverr = 1'b0;
      end

      // writes land on the edge where pready is sampled high
      if (apb_commit && i_pwrite && i_pstrb[0]) begin
         case (i_paddr)
            OFF_ENABLE_PRIMARY: s_d.en_pri = i_pwdata[7:0];
            OFF_PRIORITY_PRIMARY: s_d.pri_pri = i_pwdata[6:0];
            OFF_ENABLE_TIMER2: s_d.en_t2 = i_pwdata[7:0];
            OFF_PRIORITY_TIMER2: s_d.pri_t2 = i_pwdata[7:0];
            OFF_TRIGGER_MODE: s_d.mode = i_pwdata[7:0];
            OFF_CAPTURE_EDGE: s_d.capedge = i_pwdata[7:0];
            default: s_d.mode = s_d.mode;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_q.en_pri <= RST_ENABLE_PRIMARY;
         s_q.pri_pri <= RST_PRIORITY_PRIMARY[6:0];
         s_q.en_t2 <= RST_ENABLE_TIMER2;
         s_q.pri_t2 <= RST_PRIORITY_TIMER2;
         s_q.mode <= RST_TRIGGER_MODE;
         s_q.capedge <= RST_CAPTURE_EDGE;
         s_q.edge_flag <= '0;
         s_q.fsm <= TLIC_ST_IDLE;
         s_q.cnt <= 8'h00;
         s_q.sel <= 4'h0;
         s_q.sel_high <= 1'b0;
         s_q.svc_high <= 1'b0;
         s_q.svc_low <= 1'b0;
         s_q.pready <= 1'b0;
         s_q.prdata <= 32'h00000000;
         s_q.pslverr <= 1'b0;
         s_q.irq_req <= 1'b0;
         s_q.vector <= 16'h0000;
         s_q.wake <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_pready = s_q.pready;
   assign o_prdata = s_q.prdata;
   assign o_pslverr = s_q.pslverr;
   assign o_irq_req = s_q.irq_req;
   assign o_irq_vector = s_q.vector;
   assign o_irq_high = s_q.sel_high;
   assign o_idle_wake = s_q.wake;

endmodule : tlic_ctrl

`default_nettype wire

// ---- tb/tlic_ctrl_checker.sv ----
`timescale 1ns/1ps
`default_nettype none

module tlic_ctrl_checker (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // inputs watched
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_can_dma_busy,
   input wire logic i_idle_mode,
   input wire logic i_cpu_ack,
   // outputs watched
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_irq_req,
   input wire logic [15:0] o_irq_vector,
   input wire logic o_irq_high,
   input wire logic o_idle_wake
);
   // counts quiet cycles, saturating so long idle stretches stay legal
   logic [8:0] low_q;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         low_q <= 9'h000;
      end else if (o_irq_req) begin
         low_q <= 9'h000;
      end else if (low_q != 9'h1FF) begin
         low_q <= low_q + 9'h001;
      end
   end

   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   a_latency_min: assert property ($rose(o_irq_req) |-> low_q >= 9'd225)
      else $error("offer came before the minimum response time");
   a_dma_block: assert property (i_can_dma_busy [*3] |-> !o_irq_req)
      else $error("offer while transfer busy");
   a_vector_form: assert property (o_irq_req |-> o_irq_vector[2:0] == 3'h3 && o_irq_vector <= 16'h0073)
      else $error("vector outside table");
   a_ack_drop: assert property (o_irq_req && i_cpu_ack |=> !o_irq_req)
      else $error("offer stayed after acknowledge");
   a_offer_held: assert property ((o_irq_req && !i_cpu_ack) ##1 o_irq_req |-> $stable(o_irq_vector) && $stable(o_irq_high))
      else $error("offered vector changed while standing");
   a_idle_wake: assert property (!i_idle_mode |=> !o_idle_wake)
      else $error("wake outside idle");
   a_apb_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
      else $error("bus answer late");
   a_ready_pulse: assert property (o_pready |=> !o_pready)
      else $error("ready held too long");
   a_err_ready: assert property (o_pslverr |-> o_pready)
      else $error("error without ready");

   c_offer: cover property ($rose(o_irq_req));
   c_high_taken: cover property (o_irq_req && o_irq_high && i_cpu_ack);
   c_wake: cover property ($rose(o_idle_wake));
endmodule : tlic_ctrl_checker

bind tlic_ctrl tlic_ctrl_checker u_chk (.i_sys_clk, .i_rst_n, .i_psel, .i_penable,
   .i_can_dma_busy, .i_idle_mode, .i_cpu_ack, .o_pready, .o_pslverr, .o_irq_req,
   .o_irq_vector, .o_irq_high, .o_idle_wake);

`default_nettype wire

// ---- tb/tlic_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module tlic_cpu_model (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // controller side
   input wire logic i_irq_req,
   input wire logic [15:0] i_irq_vector,
   input wire logic i_irq_high,
   input wire logic [7:0] i_delay,
   output logic o_cpu_ack,
   output var logic o_cpu_reti
);
   logic [7:0] wait_q;
   logic [15:0] vec_q;
   logic high_q;
   int taken;

   initial o_cpu_reti = 1'b0;

   // a slow core leaves the offer standing for i_delay cycles before taking it
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cpu_ack <= 1'b0;
         wait_q <= 8'h00;
         vec_q <= 16'h0000;
         high_q <= 1'b0;
         taken <= 0;
      end else begin
         o_cpu_ack <= 1'b0;
         if (i_irq_req && !o_cpu_ack && wait_q == i_delay) begin
            o_cpu_ack <= 1'b1;
            vec_q <= i_irq_vector;
            high_q <= i_irq_high;
            taken <= taken + 1;
            wait_q <= 8'h00;
         end else if (i_irq_req && !o_cpu_ack) begin
            wait_q <= wait_q + 8'h01;
         end else begin
            wait_q <= 8'h00;
         end
      end
   end

   task automatic reti();
      @(posedge i_sys_clk);
      o_cpu_reti <= 1'b1;
      @(posedge i_sys_clk);
      o_cpu_reti <= 1'b0;
   endtask : reti
endmodule : tlic_cpu_model

`default_nettype wire

// ---- tb/two_level_interrupt_controller_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module two_level_interrupt_controller_test;
   import tlic_pkg::*;
   localparam int POS [15] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 11, 6, 12, 13, 14, 15};
   localparam int ORDER [15] = '{14, 0, 5, 10, 1, 6, 11, 2, 7, 12, 3, 8, 13, 4, 9};
   logic clk = 1'b0, rst_n = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, ack, reti, req, high, wake;
   logic [1:0] ext_n = 2'h3;
   logic [3:0] cap_pin = 4'h0;
   logic [14:0] src = 15'h0000;
   logic dma = 1'b0, idle = 1'b0;
   logic [7:0] dly = 8'h00;
   logic [15:0] vec;
   int n_mismatch = 0, comparisons = 0, cyc = 0;

   initial forever #5 clk = ~clk;

   tlic_ctrl uut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF),
      .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
      .i_external_request_n(ext_n & ~{src[2], src[0]}),
      .i_capture_pin(cap_pin), .i_timer0_irq(src[1]), .i_timer1_irq(src[3]),
      .i_uart_irq(src[4]), .i_can_irq(src[5]), .i_adc_irq(src[10]),
      .i_t2_capture_irq(src[9:6]), .i_t2_compare_irq(src[13:11]),
      .i_t2_overflow_irq(src[14]), .i_can_dma_busy(dma), .i_idle_mode(idle),
      .i_cpu_ack(ack), .i_cpu_reti(reti), .o_irq_req(req), .o_irq_vector(vec),
      .o_irq_high(high), .o_idle_wake(wake));

   tlic_cpu_model cpu (.i_sys_clk(clk), .i_rst_n(rst_n), .i_irq_req(req),
      .i_irq_vector(vec), .i_irq_high(high), .i_delay(dly), .o_cpu_ack(ack),
      .o_cpu_reti(reti));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp, "read data");
      chk(32'(e), 32'(experr), "slave error");
   endtask : rd

   function automatic logic [15:0] bits(input logic [14:0] s);
      logic [15:0] b;
      b = 16'h0000;
      for (int i = 0; i < 15; i++) if (s[i]) b[POS[i]] = 1'b1;
      return b;
   endfunction : bits

   task automatic cfg(input logic [14:0] en, input logic [14:0] hi, input logic gate);
      logic [15:0] e;
      logic [15:0] h;
      e = bits(en);
      h = bits(hi);
      wr(OFF_ENABLE_PRIMARY, {gate, e[6:0]});
      wr(OFF_ENABLE_TIMER2, e[15:8]);
      wr(OFF_PRIORITY_PRIMARY, h[7:0]);
      wr(OFF_PRIORITY_TIMER2, h[15:8]);
   endtask : cfg

   task automatic take(input int i, input logic h);
      int n0;
      n0 = cpu.taken;
      for (int k = 0; k < 600 && cpu.taken == n0; k++) @(posedge clk);
      chk(32'(cpu.taken - n0), 32'h1, "offer taken");
      chk(32'({cpu.high_q, cpu.vec_q}), 32'({h, 16'h0003 + 16'(8 * i)}), "vector");
   endtask : take

   task automatic quiet();
      int n0;
      n0 = cpu.taken;
      repeat (300) @(posedge clk);
      chk(32'(cpu.taken), 32'(n0), "nothing offered");
   endtask : quiet

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish

   // a hang counts as a mismatch; the whole run needs about 11000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      rd(OFF_ENABLE_PRIMARY, 32'h0, 1'b0);
      rd(OFF_PRIORITY_PRIMARY, 32'h0, 1'b0);
      rd(OFF_ENABLE_TIMER2, 32'h0, 1'b0);
      rd(OFF_PRIORITY_TIMER2, 32'h0, 1'b0);
      wr(OFF_PRIORITY_PRIMARY, 8'hFF);
      rd(OFF_PRIORITY_PRIMARY, 32'h7F, 1'b0);
      wr(OFF_ENABLE_PRIMARY, 8'h55);
      rd(OFF_ENABLE_PRIMARY, 32'h55, 1'b0);
      rd(8'h10, 32'h0, 1'b1);
      $display("test registers done");
      cfg(15'h0002, 15'h0000, 1'b0);
      src <= 15'h0002;
      quiet();
      wr(OFF_ENABLE_PRIMARY, 8'h82);
      take(1, 1'b0);
      rd(OFF_STATUS, 32'h00010002, 1'b0);
      src <= 15'h0000;
      cpu.reti();
      for (int i = 0; i < 15; i++) begin
         cfg(15'(1 << i), 15'h0000, 1'b1);
         src <= 15'(1 << i);
         take(i, 1'b0);
         src <= 15'h0000;
         cpu.reti();
      end
      $display("test vectors done");
      dly <= 8'd20;
      cfg(15'h7FFF, 15'h4000, 1'b1);
      src <= 15'h7FFF;
      for (int k = 0; k < 15; k++) begin
         take(ORDER[k], ORDER[k] == 14);
         src[ORDER[k]] <= 1'b0;
         cpu.reti();
      end
      dly <= 8'd0;
      $display("test order done");
      cfg(15'h0039, 15'h0028, 1'b1);
      src <= 15'h0001;
      take(0, 1'b0);
      src <= 15'h0010;
      quiet();
      src <= 15'h0018;
      take(3, 1'b1);
      src <= 15'h0030;
      quiet();
      cpu.reti();
      take(5, 1'b1);
      src <= 15'h0000;
      cpu.reti();
      cpu.reti();
      $display("test nesting done");
      cfg(15'h0002, 15'h0000, 1'b1);
      dma <= 1'b1;
      src <= 15'h0002;
      quiet();
      dma <= 1'b0;
      take(1, 1'b0);
      src <= 15'h0000;
      cpu.reti();
      $display("test transfer done");
      idle <= 1'b1;
      cfg(15'h0042, 15'h0000, 1'b1);
      src <= 15'h0040;
      repeat (10) @(posedge clk);
      chk(32'(wake), 32'h0, "wake on capture");
      src <= 15'h0042;
      repeat (10) @(posedge clk);
      chk(32'(wake), 32'h1, "wake on timer");
      src <= 15'h0000;
      idle <= 1'b0;
      $display("test idle done");
      wr(OFF_TRIGGER_MODE, 8'h06);
      wr(OFF_CAPTURE_EDGE, 8'h01);
      rd(OFF_TRIGGER_MODE, 32'h06, 1'b0);
      rd(OFF_CAPTURE_EDGE, 32'h01, 1'b0);
      cfg(15'h0044, 15'h0000, 1'b1);
      ext_n[1] <= 1'b0;
      repeat (4) @(posedge clk);
      ext_n[1] <= 1'b1;
      take(2, 1'b0);
      cpu.reti();
      cap_pin[0] <= 1'b1;
      take(6, 1'b0);
      cpu.reti();
      wr(OFF_CAPTURE_EDGE, 8'h10);
      cap_pin[0] <= 1'b0;
      take(6, 1'b0);
      cpu.reti();
      $display("test edges done");
      tally_and_finish();
   end
endmodule : two_level_interrupt_controller_test

`default_nettype wire
